// >>> mcps_monitor_model.sv
// Purpose: voltage monitor and host seen by the sequencer
// Assumes: bench paces the minimum low times
// Notes:   standby pulse carries the standby mode code
`timescale 1ns/100ps
`default_nettype none
module mcps_monitor_model (
   input  wire logic                     svOn,
   input  wire logic                     pokOn,
   input  wire logic                     sbGo,
   input  wire logic                     nmGo,
   output logic                          supplyValidSense,
   output mcps_pkg::mcps_mode_cmd_t      modeCmd,
   output logic                          powerOkInput
);
   assign supplyValidSense = svOn;
   assign powerOkInput = pokOn;
   assign modeCmd = '{valid: sbGo || nmGo,
                      value: nmGo ? mcps_pkg::MODE_NORMAL : mcps_pkg::MODE_STANDBY};
endmodule : mcps_monitor_model
`default_nettype wire

// >>> mcps_pkg.sv
// Purpose: shared constants and types of the mirror controller power sequencer
// Assumes: ref_clk at 25 MHz
// Notes:   the blanking time is kept in ms and its cycle count derived from it; the load gap is given in cycles
package mcps_pkg;
   localparam int unsigned CLK_HZ          = 25_000_000;
   localparam int unsigned MS_PER_S        = 1000;
   // power-ok blanking after supply-valid rises, in ms
   localparam int unsigned BLANK_MS        = 60;
   localparam int unsigned BLANK_CYCLES    = BLANK_MS * (CLK_HZ / MS_PER_S);
   localparam int unsigned TIMER_W         = 21;
   // shutdown sequence shape
   localparam int unsigned NUM_LOADS       = 8;
   localparam int unsigned LOAD_GAP_CYCLES = 4;
   localparam int unsigned INDEX_W         = 3;
   // power mode command values
   localparam logic [7:0]  MODE_NORMAL     = 8'h00;
   localparam logic [7:0]  MODE_STANDBY    = 8'h01;

   typedef enum logic [2:0] {
      MCPS_OFF,
      MCPS_BLANK,
      MCPS_WAIT_OK,
      MCPS_RUN,
      MCPS_SHUT_LOAD,
      MCPS_SHUT_PARK,
      MCPS_PARKED
   } mcps_state_t;

   typedef struct packed {
      logic                 load;
      logic                 park;
      logic [INDEX_W-1:0]   index;
   } mcps_mirror_cmd_t;

   typedef struct packed {
      logic                 valid;
      logic [7:0]           value;
   } mcps_mode_cmd_t;
endpackage : mcps_pkg

// >>> mcps_sequencer.sv
// Purpose: power-up reset release and orderly micromirror_array shutdown
// Assumes: all inputs synchronous to ref_clk
// Notes:   shutdown runs on a standby command or on loss of power_ok_input;
//          the shutdown takes a few dozen cycles, far inside the supply hold;
//          after a park only a normal command or a supply loss leaves the
//          parked state, so a returning power-ok alone does not restart
`timescale 1ns/100ps
`default_nettype none
module mcps_sequencer #(
   parameter int unsigned BLANK_CYCLES = mcps_pkg::BLANK_CYCLES
) (
   input  wire logic                      ref_clk,
   input  wire logic                      rst_n,
   input  wire logic                      supplyValidSense,
   input  wire logic                      powerOkInput,
   input  wire mcps_pkg::mcps_mode_cmd_t  modeCmd,
   output var  logic                      sysReset_n,
   output var  mcps_pkg::mcps_mirror_cmd_t mirrorCmd,
   output var  logic                      shutdownBusy,
   output var  logic                      mirrorParked
);

   function automatic logic isMode(input mcps_pkg::mcps_mode_cmd_t cmd,
                                   input logic [7:0] value);
      isMode = cmd.valid && (cmd.value == value);
   endfunction : isMode

   // reset is held through power-off, blanking and the wait for power-ok
   function automatic logic isReleased(input mcps_pkg::mcps_state_t st);
      isReleased = (st != mcps_pkg::MCPS_OFF) &&
                   (st != mcps_pkg::MCPS_BLANK) &&
                   (st != mcps_pkg::MCPS_WAIT_OK);
   endfunction : isReleased

   function automatic logic isShutdown(input mcps_pkg::mcps_state_t st);
      isShutdown = (st == mcps_pkg::MCPS_SHUT_LOAD) ||
                   (st == mcps_pkg::MCPS_SHUT_PARK);
   endfunction : isShutdown

   mcps_pkg::mcps_state_t               state;
   mcps_pkg::mcps_state_t               next_state;
   logic [mcps_pkg::TIMER_W-1:0]        timer;
   logic [mcps_pkg::TIMER_W-1:0]        next_timer;
   logic [mcps_pkg::INDEX_W-1:0]        loadIndex;
   logic [mcps_pkg::INDEX_W-1:0]        next_loadIndex;
   // supply-valid edge detector; it resets low so a sense already high
   // at release counts as a rise and restarts the blanking
   logic                                svPrev;
   logic                                standbyReq;
   logic                                normalReq;
   logic                                svRise;
   logic                                blankDone;
   logic                                gapDone;
   logic                                lastLoad;
   logic                                next_sysReset_n;
   logic                                next_load;
   logic                                next_park;
   logic                                next_busy;
   logic                                next_parked;

   // terminal counts of the one shared timer and of the load index
   localparam logic [mcps_pkg::TIMER_W-1:0] BLANK_LAST =
      mcps_pkg::TIMER_W'(BLANK_CYCLES - 1);
   localparam logic [mcps_pkg::TIMER_W-1:0] GAP_LAST =
      mcps_pkg::TIMER_W'(mcps_pkg::LOAD_GAP_CYCLES - 1);
   localparam logic [mcps_pkg::INDEX_W-1:0] LOAD_LAST =
      mcps_pkg::INDEX_W'(mcps_pkg::NUM_LOADS - 1);

   assign standbyReq = isMode(modeCmd, mcps_pkg::MODE_STANDBY);
   assign normalReq  = isMode(modeCmd, mcps_pkg::MODE_NORMAL);
   assign svRise     = supplyValidSense && !svPrev;
   assign blankDone  = (timer == BLANK_LAST);
   assign gapDone    = (timer == GAP_LAST);
   assign lastLoad   = (loadIndex == LOAD_LAST);

   always_comb
   begin
      next_state     = state;
      next_timer     = timer;
      next_loadIndex = loadIndex;
      unique case (state)
         mcps_pkg::MCPS_OFF:
         begin
            // timer kept clear so blanking always counts from zero
            next_timer = '0;
            if (svRise)
            begin
               next_state = mcps_pkg::MCPS_BLANK;
            end
         end
         mcps_pkg::MCPS_BLANK:
         begin
            // power-ok is not looked at while blanking
            next_timer = timer + 1'b1;
            if (blankDone)
            begin
               next_state = mcps_pkg::MCPS_WAIT_OK;
            end
         end
         mcps_pkg::MCPS_WAIT_OK:
         begin
            // no time limit here: the monitor holds power-ok low as it needs
            if (powerOkInput)
            begin
               next_state = mcps_pkg::MCPS_RUN;
            end
         end
         mcps_pkg::MCPS_RUN:
         begin
            next_timer     = '0;
            next_loadIndex = '0;
            // loss of power-ok and standby both start the same shutdown
            if (!powerOkInput || standbyReq)
            begin
               next_state = mcps_pkg::MCPS_SHUT_LOAD;
            end
         end
         mcps_pkg::MCPS_SHUT_LOAD:
         begin
            // one load per gap; the index wraps to zero after the last load
            next_timer = gapDone ? '0 : timer + 1'b1;
            if (gapDone)
            begin
               next_loadIndex = loadIndex + 1'b1;
               if (lastLoad)
               begin
                  next_state = mcps_pkg::MCPS_SHUT_PARK;
               end
            end
         end
         mcps_pkg::MCPS_SHUT_PARK:
         begin
            // park lasts one cycle, then the array rests un-landed
            next_state = mcps_pkg::MCPS_PARKED;
         end
         mcps_pkg::MCPS_PARKED:
         begin
            // a returning power-ok alone must not restart the array
            if (powerOkInput && normalReq)
            begin
               next_state = mcps_pkg::MCPS_RUN;
            end
         end
         // the eighth code of the state register is never used
         default:
         begin
            next_state     = mcps_pkg::MCPS_OFF;
            next_timer     = '0;
            next_loadIndex = '0;
         end
      endcase
      // a supply drop aborts whatever runs, shutdown included
      if (!supplyValidSense)
      begin
         next_state = mcps_pkg::MCPS_OFF;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state     <= mcps_pkg::MCPS_OFF;
         timer     <= '0;
         loadIndex <= '0;
         svPrev    <= 1'b0;
      end
      else
      begin
         state     <= next_state;
         timer     <= next_timer;
         loadIndex <= next_loadIndex;
         svPrev    <= supplyValidSense;
      end
   end

   // reset, park, busy and parked decoded from the next state so each register lines up with it; load from the current state and timer
   assign next_sysReset_n = isReleased(next_state);
   assign next_load       = (state == mcps_pkg::MCPS_SHUT_LOAD) &&
                            (timer == '0);
   assign next_park       = (next_state == mcps_pkg::MCPS_SHUT_PARK);
   assign next_busy       = isShutdown(next_state);
   assign next_parked     = (next_state == mcps_pkg::MCPS_PARKED);

   // index is held between loads; it is only meaningful with the load pulse
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sysReset_n   <= 1'b0;
         mirrorCmd    <= '0;
         shutdownBusy <= 1'b0;
         mirrorParked <= 1'b0;
      end
      else
      begin
         sysReset_n      <= next_sysReset_n;
         mirrorCmd.load  <= next_load;
         mirrorCmd.park  <= next_park;
         mirrorCmd.index <= loadIndex;
         shutdownBusy    <= next_busy;
         mirrorParked    <= next_parked;
      end
   end

endmodule : mcps_sequencer
`default_nettype wire

// >>> mcps_sequencer_assertions.sv
// Purpose: checks on the sequencer ports
// Assumes: one clock domain
// Notes:   load count is tracked over one shutdown
`timescale 1ns/100ps
`default_nettype none
module mcps_sequencer_assertions #(
   parameter int unsigned BLANK_CYCLES = mcps_pkg::BLANK_CYCLES
) (
   input wire logic                       ref_clk,
   input wire logic                       rst_n,
   input wire logic                       supplyValidSense,
   input wire logic                       powerOkInput,
   input wire mcps_pkg::mcps_mirror_cmd_t mirrorCmd,
   input wire logic                       sysReset_n,
   input wire logic                       shutdownBusy,
   input wire logic                       mirrorParked
);
   logic [3:0] loadCnt;
   int unsigned sinceRise;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n) loadCnt <= 4'h0;
      else if (!shutdownBusy) loadCnt <= 4'h0;
      else if (mirrorCmd.load) loadCnt <= loadCnt + 4'h1;
   end
   // cycles since supply-valid came up, saturating just past the blanking
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n) sinceRise <= 32'h0000_0000;
      else if (!supplyValidSense) sinceRise <= 32'h0000_0000;
      else if (sinceRise <= BLANK_CYCLES) sinceRise <= sinceRise + 32'h0000_0001;
   end
   blank_time_a: assert property (supplyValidSense && (sinceRise <= BLANK_CYCLES)
      |-> !sysReset_n) else $error("reset left inside the blanking time");
   park_once_a: assert property (mirrorCmd.park |=> !mirrorCmd.park && mirrorParked)
      else $error("park not a single pulse into parked");
   reset_release_a: assert property ($rose(sysReset_n) |-> $past(powerOkInput))
      else $error("reset left without power ok");
   blank_hold_a: assert property ($rose(supplyValidSense) |=> !sysReset_n [*8])
      else $error("reset left during blanking");
   shut_time_a: assert property ($rose(shutdownBusy) |-> ##[1:40] mirrorParked)
      else $error("shutdown too slow");
   load_order_a: assert property (mirrorCmd.load |-> mirrorCmd.index == loadCnt[2:0])
      else $error("load index out of order");
   park_last_a: assert property (mirrorCmd.park |-> loadCnt == 4'h8)
      else $error("park before all loads");
endmodule : mcps_sequencer_assertions
`default_nettype wire

// >>> testbench.sv
// Purpose: self-checking bench of the sequencer
// Assumes: blanking shortened to 20 cycles
// Notes:   low times follow the monitor minimums; the long supply holds and
//          the standby wait are scaled down to keep the run short
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic ref_clk = 0, rst_n = 0, svOn = 0, pokOn = 0, sbGo = 0, nmGo = 0;
   logic sv, pok, rstOut, busy, parked;
   mcps_pkg::mcps_mode_cmd_t   mc;
   mcps_pkg::mcps_mirror_cmd_t mir;
   int failures = 0, checksDone = 0;
   localparam int BLANK = 20;
   mcps_monitor_model i_mcps_monitor_model (.svOn(svOn), .pokOn(pokOn), .sbGo(sbGo),
      .nmGo(nmGo), .supplyValidSense(sv), .modeCmd(mc), .powerOkInput(pok));
   mcps_sequencer #(.BLANK_CYCLES(BLANK)) i_mcps_sequencer (.ref_clk(ref_clk), .rst_n(rst_n),
      .supplyValidSense(sv), .powerOkInput(pok), .modeCmd(mc), .sysReset_n(rstOut),
      .mirrorCmd(mir), .shutdownBusy(busy), .mirrorParked(parked));
   initial forever #20 ref_clk = ~ref_clk;
   task check(input string n, input logic [7:0] s, input logic [7:0] e);
      checksDone++;
      if (s !== e)
      begin
         failures++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask : check
   task report_and_stop;
      $display("checks %0d failures %0d", checksDone, failures);
      if (failures == 0 && checksDone > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : report_and_stop
   task step(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : step
   // reset is released on the 21st edge after the edge that takes the rise
   task power_up;
      svOn = 1;
      step(5);
      pokOn = 1;
      step(BLANK - 4);
      check("reset", rstOut, 0);
      step(1);
      check("reset", rstOut, 1);
   endtask : power_up
   task watch_shutdown;
      int n;
      int parks;
      n = 0;
      parks = 0;
      step(1);
      check("busy", busy, 1);
      repeat (60)
      begin
         if (mir.load === 1'b1)
         begin
            check("index", 8'(mir.index), 8'(n));
            n++;
         end
         parks += int'(mir.park);
         step(1);
      end
      check("loads", 8'(n), 8);
      check("parks", 8'(parks), 1);
      check("parked", parked, 1);
      check("busy", busy, 0);
   endtask : watch_shutdown
   task power_loss;
      pokOn = 0;
      watch_shutdown();
      step(12500);
      svOn = 0;
      step(12500);
      check("reset", rstOut, 0);
   endtask : power_loss
   task standby;
      sbGo = 1;
      step(1);
      sbGo = 0;
      watch_shutdown();
   endtask : standby
   task mid_reset;
      rst_n = 0;
      step(2);
      check("reset", rstOut, 0);
      check("busy", busy, 0);
      rst_n = 1;
      step(BLANK + 1);
      check("reset", rstOut, 0);
      step(1);
      check("reset", rstOut, 1);
   endtask : mid_reset
   task resume;
      // a standby while parked is refused
      sbGo = 1;
      step(1);
      sbGo = 0;
      step(2);
      check("busy", busy, 0);
      check("parked", parked, 1);
      nmGo = 1;
      step(1);
      nmGo = 0;
      check("parked", parked, 0);
      check("reset", rstOut, 1);
   endtask : resume
   task planned_off;
      standby();
      step(100);
      svOn = 0;
      step(1);
      check("reset", rstOut, 0);
      check("parked", parked, 0);
   endtask : planned_off
   initial
   begin
      step(10);
      rst_n = 1;
      power_up();
      power_loss();
      power_up();
      mid_reset();
      standby();
      resume();
      planned_off();
      report_and_stop();
   end
   initial
   begin
      #4_000_000;
      failures++;
      report_and_stop();
   end
endmodule : testbench
bind mcps_sequencer mcps_sequencer_assertions #(.BLANK_CYCLES(BLANK_CYCLES)) u_chk (
   .ref_clk(ref_clk), .rst_n(rst_n),
   .supplyValidSense(supplyValidSense), .powerOkInput(powerOkInput), .mirrorCmd(mirrorCmd),
   .sysReset_n(sysReset_n), .shutdownBusy(shutdownBusy), .mirrorParked(mirrorParked));
`default_nettype wire
